// ===== design/wfr_flow_calc.sv
/* Flow-rate calculator with weight/flow presentation and print trigger,
 * reached over AHB-Lite. Assumes gross/net weights come from logic on
 * hclk, that keys and digital inputs are asynchronous pins, and that a
 * non-volatile store keeps cfg_out and replays it through nv_load. */
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`default_nettype none
module wfr_flow_calc #(
    parameter int unsigned SAMPLE_DIV = wfr_pkg::SAMPLE_DIV,
    parameter int unsigned HIST_AW    = 7
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic                  hresp,
    output logic [31:0]           hrdata,
    input  wire logic [23:0]      gross_weight,
    input  wire logic [23:0]      net_weight,
    input  wire logic             net_selected,
    input  wire logic             key_toggle,
    input  wire logic             din_toggle,
    input  wire logic             key_print,
    input  wire logic             din_print,
    input  wire logic             nv_load,
    input  wire wfr_pkg::wfr_cfg_t nv_cfg,
    output wfr_pkg::wfr_cfg_t     cfg_out,
    output logic                  show_flow,
    output logic                  print_shown,
    output logic                  print_pulse,
    output logic [23:0]           print_value,
    output logic [31:0]           flow_value,
    output logic                  flow_settled
);
    typedef enum {ST_IDLE, ST_DIV, ST_DONE} wfr_div_st_t;
    function automatic logic [2:0] wfr_class(input logic [14:0] per);
        logic [2:0] k;
        k = 3'h7;
        for (int i = 7; i >= 0; i--) begin
            if (per <= (wfr_pkg::DERIV_BASE << i)) begin
                k = 3'(i);
            end
        end
        return k;
    endfunction : wfr_class
    // Rounds to the step of the range the value falls in. The top of every
    // range is a multiple of its step, so rounding never goes above the range.
    function automatic logic [14:0] wfr_round(input logic [31:0] v);
        logic [15:0] c;
        logic [15:0] st;
        logic [15:0] r;
        logic [2:0]  k;
        c = (v < 32'(wfr_pkg::DERIV_MIN)) ? 16'(wfr_pkg::DERIV_MIN) :
            (v > 32'(wfr_pkg::DERIV_MAX)) ? 16'(wfr_pkg::DERIV_MAX) : v[15:0];
        k = wfr_class(c[14:0]);
        st = 16'h0002 << k;
        r = (c + (st >> 1)) & ~(st - 16'h0001);
        return r[14:0];
    endfunction : wfr_round
    wfr_pkg::wfr_cfg_t cfg;
    assign cfg_out = cfg;
    // Pin synchronisers; stage one feeds stage two only.
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [3:0] pin_s3;
    logic [3:0] pin_rise;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
            pin_s3 <= 4'h0;
        end else begin
            pin_s1 <= {din_print, key_print, din_toggle, key_toggle};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end
    assign pin_rise = pin_s2 & ~pin_s3;

    // AHB-Lite slave: zero wait states, always OKAY.
    logic       wr_pend;
    logic [7:0] wr_addr;
    logic       addr_ok;
    logic       rd_req;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel && htrans[1] && hready;
    assign rd_req    = addr_ok && !hwrite;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr[7:0];
        end
    end
    logic wr_cmd;
    assign wr_cmd  = wr_pend && (wr_addr == wfr_pkg::ADDR_CMD);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg <= wfr_pkg::CFG_RST;
        end else if (nv_load) begin
            cfg <= nv_cfg;
            cfg.deriv_period <= wfr_round(32'(nv_cfg.deriv_period));
        end else if (wr_pend) begin
            case (wr_addr)
                wfr_pkg::ADDR_CTRL: begin
                    cfg.enable        <= hwdata[0];
                    cfg.time_base     <= wfr_pkg::wfr_tbase_t'(hwdata[2:1]);
                    cfg.din_toggle_en <= hwdata[3];
                    cfg.din_print_en  <= hwdata[4];
                end
                wfr_pkg::ADDR_DERIV: cfg.deriv_period <= wfr_round(hwdata);
                wfr_pkg::ADDR_RES: begin
                    cfg.decimals <= hwdata[1:0];
                    cfg.step_sel <= hwdata[3:2];
                end
                default: ;
            endcase
        end
    end

    // Presentation select and print requests.
    logic toggle_req;
    logic print_req;
    assign toggle_req = pin_rise[0] || (pin_rise[1] && cfg.din_toggle_en) ||
                        (wr_cmd && hwdata[0]);
    assign print_req  = pin_rise[2] || (pin_rise[3] && cfg.din_print_en) ||
                        (wr_cmd && hwdata[1]);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            show_flow <= 1'b0;
        end else if (toggle_req) begin
            show_flow <= !show_flow;
        end
    end
    // Sample-rate divider.
    logic [31:0] div_cnt;
    logic        tick;
    assign tick = (div_cnt == 32'(SAMPLE_DIV - 1));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt <= 32'h0;
        end else begin
            div_cnt <= tick ? 32'h0 : div_cnt + 32'h1;
        end
    end

    logic [15:0] show_cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            print_pulse <= 1'b0;
            print_value <= 24'h0;
            show_cnt    <= 16'h0;
        end else begin
            print_pulse <= print_req;
            if (print_req) begin
                print_value <= net_selected ? net_weight
                                            : gross_weight;
                show_cnt    <= 16'(wfr_pkg::PRINT_TICKS);
            end else if (tick && show_cnt != 16'h0) begin
                show_cnt <= show_cnt - 16'h1;
            end
        end
    end
    assign print_shown = (show_cnt != 16'h0);
    // Decimated history: one entry per flow update.
    logic [2:0]          rng;
    logic [8:0]          step;
    logic [8:0]          sub_cnt;
    logic [HIST_AW-1:0]  lag;
    logic [HIST_AW-1:0]  wp;
    logic [HIST_AW:0]    fill;
    logic [23:0]         hist [2**HIST_AW];
    logic [14:0]         per_last;
    logic                upd;
    assign rng  = wfr_class(cfg.deriv_period);
    assign step = 9'h002 << rng;
    // The shift amount is widened so that the longest range (7 + 1) does
    // not wrap to zero.
    assign lag  = HIST_AW'(cfg.deriv_period >> (4'(rng) + 4'h1));
    assign upd  = tick && cfg.enable && (sub_cnt == step - 9'h001);
    always_ff @(posedge hclk) begin
        if (upd) begin
            hist[wp] <= gross_weight;
        end
    end
    logic restart;
    assign restart = !cfg.enable || (per_last != cfg.deriv_period);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_cnt <= 9'h000;
            wp      <= '0;
            fill    <= '0;
            per_last <= wfr_pkg::DERIV_RST;
        end else begin
            per_last <= cfg.deriv_period;
            if (restart) begin
                sub_cnt <= 9'h000;
                fill    <= '0;
            end else if (tick) begin
                sub_cnt <= upd ? 9'h000 : sub_cnt + 9'h001;
                if (upd) begin
                    wp <= wp + 1'b1;
                    if (fill <= {1'b0, lag}) begin
                        fill <= fill + 1'b1;
                    end
                end
            end
        end
    end
    // Sequential divider: |diff| * time base * 10^dec / (period * step).
    wfr_div_st_t st;
    logic [63:0] quo;
    logic [63:0] rem;
    logic [31:0] dvs;
    logic [6:0]  bit_cnt;
    logic        neg;
    logic signed [24:0] diff;
    logic [24:0] mag;
    logic [20:0] tb_mult;
    logic [9:0]  pow10;
    logic [3:0]  qstep;
    logic [64:0] trial;
    logic [63:0] scaled;
    assign diff = $signed({gross_weight[23], gross_weight}) -
                  $signed({hist[wp - lag][23], hist[wp - lag]});
    assign mag  = diff[24] ? 25'(-diff) : diff;
    always_comb begin
        case (cfg.time_base)
            wfr_pkg::TB_MIN:  tb_mult = 21'h004650;
            wfr_pkg::TB_HOUR: tb_mult = 21'h107AC0;
            default:          tb_mult = 21'h00012C;
        endcase
        case (cfg.decimals)
            2'h1:    pow10 = 10'h00A;
            2'h2:    pow10 = 10'h064;
            2'h3:    pow10 = 10'h3E8;
            default: pow10 = 10'h001;
        endcase
        case (cfg.step_sel)
            2'h1:    qstep = 4'h2;
            2'h2:    qstep = 4'h5;
            2'h3:    qstep = 4'hA;
            default: qstep = 4'h1;
        endcase
    end
    assign trial  = {rem, quo[63]} - {33'h0, dvs};
    assign scaled = quo * 64'(qstep);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st           <= ST_IDLE;
            quo          <= 64'h0;
            rem          <= 64'h0;
            dvs          <= 32'h0;
            bit_cnt      <= 7'h00;
            neg          <= 1'b0;
            flow_value   <= 32'h0;
            flow_settled <= 1'b0;
        end else begin
            case (st)
                ST_IDLE: begin
                    if (!cfg.enable) begin
                        flow_value   <= 32'h0;
                        flow_settled <= 1'b0;
                    end else if (upd) begin
                        quo <= 64'(mag) * 64'(tb_mult) * 64'(pow10);
                        rem <= 64'h0;
                        dvs <= 32'(cfg.deriv_period) * 32'(qstep);
                        neg <= diff[24];
                        bit_cnt <= 7'h00;
                        flow_settled <= (fill > {1'b0, lag});
                        st  <= ST_DIV;
                    end
                end
                ST_DIV: begin
                    if (!trial[64]) begin
                        rem <= trial[63:0];
                        quo <= {quo[62:0], 1'b1};
                    end else begin
                        rem <= {rem[62:0], quo[63]};
                        quo <= {quo[62:0], 1'b0};
                    end
                    bit_cnt <= bit_cnt + 7'h01;
                    st      <= (bit_cnt == 7'h3F) ? ST_DONE : ST_DIV;
                end
                ST_DONE: begin
                    flow_value <= neg ? 32'(-scaled) : scaled[31:0];
                    st <= ST_IDLE;
                end
                default: st <= ST_IDLE;
            endcase
        end
    end
    // Read data registered in the address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (rd_req) begin
            case (haddr[7:0])
                wfr_pkg::ADDR_CTRL:   hrdata <= {27'h0, cfg.din_print_en,
                    cfg.din_toggle_en, cfg.time_base, cfg.enable};
                wfr_pkg::ADDR_DERIV:  hrdata <= 32'(cfg.deriv_period);
                wfr_pkg::ADDR_RES:    hrdata <= {28'h0, cfg.step_sel,
                    cfg.decimals};
                wfr_pkg::ADDR_FLOW:   hrdata <= flow_value;
                wfr_pkg::ADDR_STATUS: hrdata <= {29'h0, print_shown,
                    show_flow, flow_settled};
                wfr_pkg::ADDR_PRINT:  hrdata <= {{8{print_value[23]}},
                    print_value};
                default:              hrdata <= 32'h0;
            endcase
        end
    end
endmodule : wfr_flow_calc
`default_nettype wire

// ===== design/wfr_pkg.sv
/*
 * Shared constants and types of the weigh flow-rate block: register map,
 * reset values, timing counts and the configuration record.
 * Assumes a 100 MHz system clock and a 32-bit AHB-Lite register bus.
 */
`default_nettype none
package wfr_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned SAMPLE_HZ     = 300;
    localparam int unsigned SAMPLE_DIV    = CLK_HZ / SAMPLE_HZ;
    localparam int unsigned PRINT_SHOW_MS = 1000;
    localparam int unsigned PRINT_TICKS   = PRINT_SHOW_MS * SAMPLE_HZ / 1000;

    // Derivation period in samples (1/300 s each).
    localparam logic [14:0] DERIV_MIN  = 15'h0096;
    localparam logic [14:0] DERIV_MAX  = 15'h6400;
    localparam logic [14:0] DERIV_BASE = 15'h00C8;
    localparam logic [14:0] DERIV_RST  = 15'h012C;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_DERIV  = 8'h04;
    localparam logic [7:0] ADDR_RES    = 8'h08;
    localparam logic [7:0] ADDR_FLOW   = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CMD    = 8'h14;
    localparam logic [7:0] ADDR_PRINT  = 8'h18;

    // CTRL bits: 0 enable, 2:1 time base, 3 din toggle, 4 din print.
    // RES bits: 1:0 decimals, 3:2 step (1, 2, 5, 10).
    // CMD bits: 0 toggle weight/flow, 1 print.
    // STATUS bits: 0 settled, 1 flow shown, 2 print shown.
    typedef enum logic [1:0] {TB_SEC, TB_MIN, TB_HOUR} wfr_tbase_t;

    typedef struct packed {
        logic        enable;
        wfr_tbase_t  time_base;
        logic        din_toggle_en;
        logic        din_print_en;
        logic [14:0] deriv_period;
        logic [1:0]  decimals;
        logic [1:0]  step_sel;
    } wfr_cfg_t;

    localparam wfr_cfg_t CFG_RST = '{1'b0, TB_SEC, 1'b0, 1'b0,
                                     DERIV_RST, 2'h0, 2'h0};
endpackage : wfr_pkg
`default_nettype wire

// ===== tb/wfr_monitor.sv
/* Port checker for the flow-rate block, bound to wfr_flow_calc.
   Assumes one clock hclk and the active-low reset hresetn. */
`default_nettype none
module wfr_monitor (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic [23:0]       gross_weight,
    input wire logic [23:0]       net_weight,
    input wire logic              net_selected,
    input wire logic              key_print,
    input wire wfr_pkg::wfr_cfg_t cfg_out,
    input wire logic              show_flow,
    input wire logic              print_shown,
    input wire logic              print_pulse,
    input wire logic [23:0]       print_value,
    input wire logic [31:0]       flow_value
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        cmd_wr_q;
    logic [23:0] shown_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_wr_q <= 1'b0;
            shown_q  <= 24'h000000;
        end else begin
            cmd_wr_q <= hsel && htrans[1] && hready && hwrite
                        && haddr[7:0] == wfr_pkg::ADDR_CMD;
            shown_q  <= net_selected ? net_weight : gross_weight;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not OKAY");
    a_pulse_single: assert property (print_pulse |=> !print_pulse)
        else $error("print pulse longer than one cycle");
    a_print_shown: assert property (
        print_pulse |-> ##[0:2] print_shown)
        else $error("print indication missing");
    a_print_value: assert property (
        print_pulse |-> print_value == shown_q)
        else $error("printed value is not the presented one");
    a_flow_off: assert property (
        (!cfg_out.enable)[*8] |-> ##70
        (flow_value == 32'h0 || cfg_out.enable))
        else $error("flow not zero while disabled");
    a_cmd_toggle: assert property (
        cmd_wr_q && hwdata[0] |=> show_flow != $past(show_flow))
        else $error("host toggle ignored");
    a_cmd_print: assert property (
        cmd_wr_q && hwdata[1] |-> ##[1:2] print_pulse)
        else $error("host print ignored");
    a_pin_print: assert property (
        $rose(key_print) |-> ##[2:6] print_pulse)
        else $error("print key ignored");
    a_period_range: assert property (
        cfg_out.deriv_period >= wfr_pkg::DERIV_MIN
        && cfg_out.deriv_period <= wfr_pkg::DERIV_MAX)
        else $error("period outside its range");
endmodule : wfr_monitor

bind wfr_flow_calc wfr_monitor u_mon (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .gross_weight,
    .net_weight, .net_selected, .key_print, .cfg_out, .show_flow,
    .print_shown, .print_pulse, .print_value, .flow_value);
`default_nettype wire

// ===== tb/wfr_weight_src.sv
/* Weight sample source in front of the flow-rate block.
   Assumes the bench sets the ramp rate; net is gross less a fixed tare. */
`default_nettype none
module wfr_weight_src #(
    parameter int unsigned DIV  = 50,
    parameter logic [23:0] W0   = 24'h000080,
    parameter logic [23:0] TARE = 24'h000100
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [23:0] rate,
    output logic [23:0]      gross_weight,
    output logic [23:0]      net_weight
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned cnt;

    // Moving once per sample period makes every sample differ by one
    // rate step, whatever the phase of the block's own sample tick.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt          <= 0;
            gross_weight <= W0;
        end else if (cnt == DIV - 1) begin
            cnt          <= 0;
            gross_weight <= gross_weight + rate;
        end else begin
            cnt <= cnt + 1;
        end
    end
    assign net_weight = gross_weight - TARE;
endmodule : wfr_weight_src
`default_nettype wire

// ===== tb/test_weigh_flow_rate_calc.sv
/* Self-checking bench of the flow-rate block over AHB-Lite.
   Assumes the block runs with a sample divider of 50 cycles. */
`default_nettype none
module test_weigh_flow_rate_calc;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] W0   = 24'h000080;
    localparam logic [23:0] TARE = 24'h000100;
    logic              hclk, hresetn, hsel, hwrite, hready, hreadyout;
    logic              hresp, nv_load, net_selected, show_flow;
    logic              print_shown, print_pulse, flow_settled;
    logic [1:0]        htrans;
    logic [3:0]        pins;
    logic [23:0]       gross_weight, net_weight, print_value, rate;
    logic [31:0]       haddr, hwdata, hrdata, flow_value;
    wfr_pkg::wfr_cfg_t nv_cfg, cfg_out;
    int                n_mismatch = 0;
    int                cmp_count = 0;

    assign hready = hreadyout;
    wfr_flow_calc #(.SAMPLE_DIV(50)) DUT (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout,
        .hresp, .hrdata, .gross_weight, .net_weight, .net_selected,
        .key_toggle(pins[0]), .din_toggle(pins[1]), .key_print(pins[2]),
        .din_print(pins[3]), .nv_load, .nv_cfg, .cfg_out, .show_flow,
        .print_shown, .print_pulse, .print_value, .flow_value,
        .flow_settled);
    wfr_weight_src #(.DIV(50), .W0(W0), .TARE(TARE)) u_src (.hclk,
        .hresetn, .rate, .gross_weight, .net_weight);

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h", $time, what, got);
        end
    endtask : chk

    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input string what);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(q, e, what);
    endtask : rdc

    task automatic tick(input int n);
        repeat (n * 50) @(posedge hclk);
    endtask : tick

    // Raises one pin and watches ten cycles for the print pulse.
    task automatic pin(input int i, input logic exp);
        logic seen = 1'b0;
        pins[i] <= 1'b1;
        repeat (10) begin
            @(posedge hclk);
            if (print_pulse === 1'b1) seen = 1'b1;
        end
        pins[i] <= 1'b0;
        @(posedge hclk);
        chk({31'h0, seen}, {31'h0, exp}, "print pulse");
    endtask : pin

    task automatic t_regs;
        rdc(wfr_pkg::ADDR_CTRL, 32'h0, "ctrl reset");
        rdc(wfr_pkg::ADDR_DERIV, 32'h12C, "period reset");
        rdc(wfr_pkg::ADDR_RES, 32'h0, "res reset");
        rdc(8'h1C, 32'h0, "unmapped");
        nv_cfg  <= '{1'b0, wfr_pkg::TB_SEC, 1'b0, 1'b0, 15'h012D,
                     2'h1, 2'h0};
        nv_load <= 1'b1;
        @(posedge hclk);
        nv_load <= 1'b0;
        @(posedge hclk);
        chk({17'h0, cfg_out.deriv_period}, 32'h12C, "nv period");
        rdc(wfr_pkg::ADDR_RES, 32'h1, "nv res");
        $display("test regs done");
    endtask : t_regs

    task automatic t_round;
        logic [14:0] wv [7] = '{15'h000A, 15'h0096, 15'h00C9, 15'h012D,
                                15'h018F, 15'h03E9, 15'h7530};
        logic [31:0] ev [7] = '{32'h0096, 32'h0096, 32'h00C8, 32'h012C,
                                32'h0190, 32'h03F0, 32'h6400};
        for (int i = 0; i < 7; i++) begin
            wr(wfr_pkg::ADDR_DERIV, {17'h0, wv[i]});
            rdc(wfr_pkg::ADDR_DERIV, ev[i], "round");
        end
        $display("test round done");
    endtask : t_round

    task automatic t_toggle;
        wr(wfr_pkg::ADDR_CMD, 32'h1);
        rdc(wfr_pkg::ADDR_STATUS, 32'h2, "host toggle");
        pin(0, 1'b0);
        chk({31'h0, show_flow}, 32'h0, "key toggle");
        pin(1, 1'b0);
        chk({31'h0, show_flow}, 32'h0, "input off");
        wr(wfr_pkg::ADDR_CTRL, 32'h8);
        pin(1, 1'b0);
        chk({31'h0, show_flow}, 32'h1, "input toggle");
        $display("test toggle done");
    endtask : t_toggle

    task automatic t_print;
        net_selected <= 1'b1;
        wr(wfr_pkg::ADDR_CMD, 32'h2);
        // The capture lands on the edge that ends the write; look one later.
        @(posedge hclk);
        chk({8'h0, print_value}, {8'h0, W0 - TARE}, "net");
        rdc(wfr_pkg::ADDR_PRINT, 32'hFFFFFF80, "print reg");
        rdc(wfr_pkg::ADDR_STATUS, 32'h6, "print shown");
        net_selected <= 1'b0;
        pin(2, 1'b1);
        chk({8'h0, print_value}, {8'h0, W0}, "gross");
        pin(3, 1'b0);
        wr(wfr_pkg::ADDR_CTRL, 32'h10);
        pin(3, 1'b1);
        $display("test print done");
    endtask : t_print

    task automatic t_flow;
        logic [31:0] cv [3] = '{32'h3, 32'h5, 32'h1};
        logic [31:0] rv [3] = '{32'h0, 32'h0, 32'h5};
        logic [23:0] wv [3] = '{24'h000002, 24'h000002, 24'hFFFFFE};
        logic [31:0] ev [3] = '{32'h8CA0, 32'h20F580, 32'hFFFFE890};
        logic [31:0] q;
        int          n;
        wr(wfr_pkg::ADDR_CTRL, 32'h0);
        // Whole units, step 1: the register test left one decimal set.
        wr(wfr_pkg::ADDR_RES, 32'h0);
        wr(wfr_pkg::ADDR_DERIV, 32'h96);
        rate <= 24'h000002;
        wr(wfr_pkg::ADDR_CTRL, 32'h1);
        tick(60);
        ahb(1'b0, wfr_pkg::ADDR_STATUS, 32'h0, q);
        chk(q & 32'h1, 32'h0, "early settle");
        for (n = 0; n < 20000 && flow_settled !== 1'b1; n++)
            @(posedge hclk);
        chk({31'h0, flow_settled}, 32'h1, "settled");
        tick(10);
        rdc(wfr_pkg::ADDR_FLOW, 32'h258, "flow");
        for (int i = 0; i < 3; i++) begin
            wr(wfr_pkg::ADDR_CTRL, cv[i]);
            wr(wfr_pkg::ADDR_RES, rv[i]);
            rate <= wv[i];
            tick(200);
            rdc(wfr_pkg::ADDR_FLOW, ev[i], "scaled flow");
        end
        wr(wfr_pkg::ADDR_CTRL, 32'h0);
        tick(20);
        rdc(wfr_pkg::ADDR_FLOW, 32'h0, "disabled");
        $display("test flow done");
    endtask : t_flow

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    initial begin
        repeat (80000) @(posedge hclk);
        n_mismatch++;
        end_of_test;
    end

    initial begin
        hresetn      = 1'b0;
        hsel         = 1'b0;
        haddr        = 32'h0;
        htrans       = 2'h0;
        hwrite       = 1'b0;
        hwdata       = 32'h0;
        pins         = 4'h0;
        rate         = 24'h000000;
        net_selected = 1'b0;
        nv_load      = 1'b0;
        nv_cfg       = wfr_pkg::CFG_RST;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs;
        t_round;
        t_toggle;
        t_print;
        t_flow;
        end_of_test;
    end
endmodule : test_weigh_flow_rate_calc
`default_nettype wire
